/* File: pup_top.sv */
// Purpose: pin configuration and data logic of two 8-bit general purpose ports
// Assumes: pins and peripheral controls are synchronous to ref_clk_in
// Notes: registers reached over AHB-Lite; pad outputs lag settings by one cycle
//
// Chosen here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "pup_params.svh"
// Functional notes
// R1: pull enable bit switches input pull device
// R2: on outputs, pull only in wired-or mode
// R3: polarity one pulls down, zero pulls up
// R4: wired-or drives zero low, one floats
// R5: open-drain choice holds for any pin owner
// R6: open-drain bit ignored on input pins
// R7: second port output drives stored data bit
// R8: data read: stored if output, else pin
// R9: bit 5 serial clock overrides GPIO control
// R10: reserved register reads zero, ignores writes
// R11: config and data registers always accessible
// R12: direction one is output, zero input
// R13: peripheral forces direction, stored bit kept
// R14: open-drain bit one open-drain, reset push-pull
// R15: all config registers eight bits, bit-per-pin
module pup_top
   import pup_pkg::*;
#(
   parameter int PINS = 8
) (
   input wire logic ref_clk_in,
   input wire logic nrst_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   input wire logic [PINS-1:0] fp_pin_in,
   output logic [PINS-1:0] fp_pin_out,
   output logic [PINS-1:0] fp_pin_oe_out,
   output logic [PINS-1:0] fp_pull_up_out,
   output logic [PINS-1:0] fp_pull_dn_out,
   input wire logic [PINS-1:0] fp_periph_en_in,
   input wire logic [PINS-1:0] fp_periph_dir_in,
   input wire logic [PINS-1:0] fp_periph_data_in,
   output logic [PINS-1:0] fp_periph_rx_out,
   input wire logic [PINS-1:0] sp_pin_in,
   output logic [PINS-1:0] sp_pin_out,
   output logic [PINS-1:0] sp_pin_oe_out,
   input wire logic [PINS-1:0] sp_periph_en_in,
   input wire logic [PINS-1:0] sp_periph_dir_in,
   input wire logic [PINS-1:0] sp_periph_data_in,
   output logic [PINS-1:0] sp_periph_rx_out
);
   // register file, one bit per pin at its own position
   pup_byte_t pull_enable_bank; // see R15
   pup_byte_t pull_polarity_bank;
   pup_byte_t open_drain_select_bank;
   pup_byte_t second_port_data;
   pup_byte_t first_port_direction_bits;
   pup_byte_t second_port_direction_bits;
   pup_byte_t first_port_data_bits;

   logic rd_en;
   logic [7:0] rd_addr;
   pup_byte_t rd_data;
   logic wr_en;
   logic [7:0] wr_addr;
   pup_byte_t wr_data;
   pup_sel_e wr_sel;
   pup_sel_e rd_sel;
   pup_byte_t sp_alt_en;
   pup_byte_t sp_readback;

   function automatic pup_sel_e decode(input logic [7:0] addr);
      pup_sel_e sel;
      sel = PUP_SEL_NONE;
      case (addr)
         `PUP_OFF_PULL_EN: sel = PUP_SEL_PULL_EN;
         `PUP_OFF_PULL_POL: sel = PUP_SEL_PULL_POL;
         `PUP_OFF_OD_SEL: sel = PUP_SEL_OD_SEL;
         `PUP_OFF_RSVD: sel = PUP_SEL_RSVD;
         `PUP_OFF_SP_DATA: sel = PUP_SEL_SP_DATA;
         `PUP_OFF_FP_DIR: sel = PUP_SEL_FP_DIR;
         `PUP_OFF_SP_DIR: sel = PUP_SEL_SP_DIR;
         `PUP_OFF_FP_DATA: sel = PUP_SEL_FP_DATA;
         `PUP_OFF_FP_PIN: sel = PUP_SEL_FP_PIN;
         default: sel = PUP_SEL_NONE;
      endcase
      return sel;
   endfunction : decode

   pup_ahb_slave u_bus (
      .ref_clk_in(ref_clk_in),
      .nrst_in(nrst_in),
      .hsel_in(hsel_in),
      .haddr_in(haddr_in),
      .htrans_in(htrans_in),
      .hwrite_in(hwrite_in),
      .hsize_in(hsize_in),
      .hwdata_in(hwdata_in),
      .hready_in(hready_in),
      .hrdata_out(hrdata_out),
      .hreadyout_out(hreadyout_out),
      .hresp_out(hresp_out),
      .rd_en_out(rd_en),
      .rd_addr_out(rd_addr),
      .rd_data_in(rd_data),
      .wr_en_out(wr_en),
      .wr_addr_out(wr_addr),
      .wr_data_out(wr_data)
   );

   assign wr_sel = wr_en ? decode(wr_addr) : PUP_SEL_NONE;
   assign rd_sel = rd_en ? decode(rd_addr) : PUP_SEL_NONE;

   // no mode or sequencing gate on any register write
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         pull_enable_bank <= `PUP_RST_BYTE;
      end else if (wr_sel == PUP_SEL_PULL_EN) begin
         pull_enable_bank <= wr_data; // see R11
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         pull_polarity_bank <= `PUP_RST_BYTE;
      end else if (wr_sel == PUP_SEL_PULL_POL) begin
         pull_polarity_bank <= wr_data; // see R11
      end
   end

   // resets to all push-pull
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         open_drain_select_bank <= `PUP_RST_BYTE; // see R14
      end else if (wr_sel == PUP_SEL_OD_SEL) begin
         open_drain_select_bank <= wr_data; // see R11
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         second_port_data <= `PUP_RST_BYTE;
      end else if (wr_sel == PUP_SEL_SP_DATA) begin
         // stored even for input pins, shows up once switched to output
         second_port_data <= wr_data; // see R11
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         first_port_direction_bits <= `PUP_RST_BYTE;
      end else if (wr_sel == PUP_SEL_FP_DIR) begin
         first_port_direction_bits <= wr_data;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         second_port_direction_bits <= `PUP_RST_BYTE;
      end else if (wr_sel == PUP_SEL_SP_DIR) begin
         second_port_direction_bits <= wr_data;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         first_port_data_bits <= `PUP_RST_BYTE;
      end else if (wr_sel == PUP_SEL_FP_DATA) begin
         first_port_data_bits <= wr_data;
      end
   end

   // buffered pin state, also handed to the shared peripherals
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         fp_periph_rx_out <= `PUP_RST_BYTE;
         sp_periph_rx_out <= `PUP_RST_BYTE;
      end else begin
         fp_periph_rx_out <= fp_pin_in;
         sp_periph_rx_out <= sp_pin_in;
      end
   end

   // pins without an alternate function ignore any peripheral request
   assign sp_alt_en = sp_periph_en_in & `PUP_SP_ALT_MASK; // see R7 see R9

   // stored bit where the direction bit is one, else pin state
   assign sp_readback = (second_port_direction_bits & second_port_data)
                        | (~second_port_direction_bits & sp_periph_rx_out); // see R8

   always_comb begin
      rd_data = `PUP_RST_BYTE;
      case (rd_sel)
         PUP_SEL_PULL_EN: rd_data = pull_enable_bank;
         PUP_SEL_PULL_POL: rd_data = pull_polarity_bank;
         PUP_SEL_OD_SEL: rd_data = open_drain_select_bank;
         PUP_SEL_RSVD: rd_data = `PUP_RSVD_READ; // see R10
         PUP_SEL_SP_DATA: rd_data = sp_readback; // see R8
         PUP_SEL_FP_DIR: rd_data = first_port_direction_bits;
         PUP_SEL_SP_DIR: rd_data = second_port_direction_bits;
         PUP_SEL_FP_DATA: rd_data = first_port_data_bits;
         PUP_SEL_FP_PIN: rd_data = fp_periph_rx_out;
         default: rd_data = `PUP_RST_BYTE;
      endcase
   end

   // first port: full pull and wired-or control per pin
   for (genvar i = 0; i < PINS; i++) begin : g_fp
      pup_pad_cell u_pad (
         .ref_clk_in(ref_clk_in),
         .nrst_in(nrst_in),
         .dir_in(first_port_direction_bits[i]),
         .data_in(first_port_data_bits[i]),
         .pull_en_in(pull_enable_bank[i]),
         .pull_pol_in(pull_polarity_bank[i]),
         .od_sel_in(open_drain_select_bank[i]),
         .periph_en_in(fp_periph_en_in[i]),
         .periph_dir_in(fp_periph_dir_in[i]),
         .periph_data_in(fp_periph_data_in[i]),
         .pin_out(fp_pin_out[i]),
         .pin_oe_out(fp_pin_oe_out[i]),
         .pull_up_out(fp_pull_up_out[i]),
         .pull_dn_out(fp_pull_dn_out[i])
      );
   end

   // second port: push-pull, no pull devices controlled here
   for (genvar i = 0; i < PINS; i++) begin : g_sp
      pup_pad_cell u_pad (
         .ref_clk_in(ref_clk_in),
         .nrst_in(nrst_in),
         .dir_in(second_port_direction_bits[i]),
         .data_in(second_port_data[i]), // see R7
         .pull_en_in(1'b0),
         .pull_pol_in(1'b0),
         .od_sel_in(1'b0),
         .periph_en_in(sp_alt_en[i]),
         .periph_dir_in(sp_periph_dir_in[i]),
         .periph_data_in(sp_periph_data_in[i]),
         .pin_out(sp_pin_out[i]),
         .pin_oe_out(sp_pin_oe_out[i]),
         .pull_up_out(),
         .pull_dn_out()
      );
   end
endmodule : pup_top
`default_nettype wire

/* File: pup_params.svh */
// Purpose: named offsets, reset values and bus codes for the port pad unit
// Assumes: included by its bare name from every design file that needs it
// Notes: definitions only
`ifndef PUP_PARAMS_SVH
`define PUP_PARAMS_SVH

// register byte offsets, low address byte only
`define PUP_OFF_PULL_EN 8'h00
`define PUP_OFF_PULL_POL 8'h04
`define PUP_OFF_OD_SEL 8'h08
`define PUP_OFF_RSVD 8'h0c
`define PUP_OFF_SP_DATA 8'h10
`define PUP_OFF_FP_DIR 8'h14
`define PUP_OFF_SP_DIR 8'h18
`define PUP_OFF_FP_DATA 8'h1c
`define PUP_OFF_FP_PIN 8'h20

// reset values
`define PUP_RST_BYTE 8'h00
`define PUP_RST_WORD 32'h0000_0000
`define PUP_RSVD_READ 8'h00

// second port bits 7-6 carry no alternate function
`define PUP_SP_ALT_MASK 8'h3f

// bus codes
`define PUP_HSIZE_WORD 3'h2
`define PUP_HRESP_OKAY 1'h0
`define PUP_ADDR_ALIGN 2'h0
`define PUP_PAD_ZERO 24'h00_0000

`endif

/* File: pup_pkg.sv */
// Purpose: shared types of the port pad unit
// Assumes: nothing beyond the standard
// Notes: register select is decoded from the low address byte
package pup_pkg;
   typedef logic [7:0] pup_byte_t;
   typedef enum logic [3:0] {
      PUP_SEL_NONE,
      PUP_SEL_PULL_EN,
      PUP_SEL_PULL_POL,
      PUP_SEL_OD_SEL,
      PUP_SEL_RSVD,
      PUP_SEL_SP_DATA,
      PUP_SEL_FP_DIR,
      PUP_SEL_SP_DIR,
      PUP_SEL_FP_DATA,
      PUP_SEL_FP_PIN
   } pup_sel_e;
endpackage : pup_pkg

/* File: pup_pad_cell.sv */
// Purpose: drive, enable and pull control of one port pin
// Assumes: all controls synchronous to ref_clk_in
// Notes: outputs registered, so a setting reaches the pin one cycle later
`timescale 1ns/1ns
`default_nettype none
module pup_pad_cell (
   input wire logic ref_clk_in,
   input wire logic nrst_in,
   input wire logic dir_in,
   input wire logic data_in,
   input wire logic pull_en_in,
   input wire logic pull_pol_in,
   input wire logic od_sel_in,
   input wire logic periph_en_in,
   input wire logic periph_dir_in,
   input wire logic periph_data_in,
   output logic pin_out,
   output logic pin_oe_out,
   output logic pull_up_out,
   output logic pull_dn_out
);
   logic eff_dir;
   logic eff_val;
   logic eff_od;
   logic pull_on;

   always_comb begin
      // peripheral forces direction, stored bit untouched
      eff_dir = periph_en_in ? periph_dir_in : dir_in; // see R12 see R13
      eff_val = periph_en_in ? periph_data_in : data_in; // see R7 see R9
      // open-drain applies whoever owns the pin, never on inputs
      eff_od = od_sel_in & eff_dir; // see R5 see R6 see R14
      pull_on = pull_en_in & (~eff_dir | eff_od); // see R1 see R2
   end

   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         pin_out <= 1'b0;
         pin_oe_out <= 1'b0;
         pull_up_out <= 1'b0;
         pull_dn_out <= 1'b0;
      end else begin
         // wired-or: drive a zero low, leave a one floating
         pin_out <= eff_od ? 1'b0 : eff_val; // see R4
         pin_oe_out <= eff_dir & (~eff_od | ~eff_val); // see R4
         pull_up_out <= pull_on & ~pull_pol_in; // see R3
         pull_dn_out <= pull_on & pull_pol_in; // see R3
      end
   end
endmodule : pup_pad_cell
`default_nettype wire

/* File: pup_ahb_slave.sv */
// Purpose: zero-wait AHB-Lite slave front end for the register file
// Assumes: single word transfers; reads answered from a flop in the data phase
// Notes: only the low address byte is decoded, so the map aliases above it
`timescale 1ns/1ns
`default_nettype none
`include "pup_params.svh"
module pup_ahb_slave (
   input wire logic ref_clk_in,
   input wire logic nrst_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   output logic rd_en_out,
   output logic [7:0] rd_addr_out,
   input wire logic [7:0] rd_data_in,
   output logic wr_en_out,
   output logic [7:0] wr_addr_out,
   output logic [7:0] wr_data_out
);
   logic accept;
   logic wr_pend;

   // narrow or misaligned transfers complete OKAY but touch nothing
   assign accept = hsel_in & htrans_in[1] & hready_in & (hsize_in == `PUP_HSIZE_WORD)
                   & (haddr_in[1:0] == `PUP_ADDR_ALIGN);
   assign rd_en_out = accept & ~hwrite_in;
   assign rd_addr_out = haddr_in[7:0];
   assign wr_en_out = wr_pend;
   assign wr_data_out = hwdata_in[7:0];

   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         wr_pend <= 1'b0;
         wr_addr_out <= `PUP_RST_BYTE;
      end else if (hready_in) begin
         wr_pend <= accept & hwrite_in;
         if (accept) begin
            wr_addr_out <= haddr_in[7:0];
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         hrdata_out <= `PUP_RST_WORD;
      end else if (rd_en_out) begin
         hrdata_out <= {`PUP_PAD_ZERO, rd_data_in};
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         hreadyout_out <= 1'b1;
         hresp_out <= `PUP_HRESP_OKAY;
      end else begin
         hreadyout_out <= 1'b1;
         hresp_out <= `PUP_HRESP_OKAY;
      end
   end
endmodule : pup_ahb_slave
`default_nettype wire

/* File: pup_pin_model.sv */
// Purpose: pin levels seen at the pads of one port
// Assumes: outside source drives a pin only where ext_en_in is high
// Notes: a pin left floating wanders every cycle
`timescale 1ns/1ns
`default_nettype none
module pup_pin_model (
   input wire logic ref_clk_in,
   input wire logic [7:0] oe_in,
   input wire logic [7:0] out_in,
   input wire logic [7:0] up_in,
   input wire logic [7:0] dn_in,
   input wire logic [7:0] ext_en_in,
   input wire logic [7:0] ext_val_in,
   output logic [7:0] pin_out
);
   logic [7:0] wander = 8'h55;
   // no keeper on a floating pin, so never hand back a stale level
   always_ff @(posedge ref_clk_in) begin
      wander <= ~wander;
   end
   always_comb begin
      pin_out = (oe_in & out_in) | (~oe_in & ext_en_in & ext_val_in);
      pin_out = pin_out | (~oe_in & ~ext_en_in & (up_in | (~dn_in & wander)));
   end
endmodule : pup_pin_model
`default_nettype wire

/* File: pup_top_monitor.sv */
// Purpose: bus and pad relations of the port pad unit
// Assumes: one clock, pads lag their cause by one edge
// Notes: helper flops hold the cause for the next edge
`timescale 1ns/1ns
`default_nettype none
module pup_top_monitor #(
   parameter int PINS = 8
) (
   input wire logic ref_clk_in,
   input wire logic nrst_in,
   input wire logic [31:0] hrdata_out,
   input wire logic hreadyout_out,
   input wire logic hresp_out,
   input wire logic [PINS-1:0] fp_pin_in,
   input wire logic [PINS-1:0] fp_pin_out,
   input wire logic [PINS-1:0] fp_pin_oe_out,
   input wire logic [PINS-1:0] fp_pull_up_out,
   input wire logic [PINS-1:0] fp_pull_dn_out,
   input wire logic [PINS-1:0] fp_periph_en_in,
   input wire logic [PINS-1:0] fp_periph_dir_in,
   input wire logic [PINS-1:0] fp_periph_data_in,
   input wire logic [PINS-1:0] fp_periph_rx_out,
   input wire logic [PINS-1:0] sp_periph_en_in,
   input wire logic [PINS-1:0] sp_periph_dir_in,
   input wire logic [PINS-1:0] sp_periph_data_in,
   input wire logic [PINS-1:0] sp_pin_out,
   input wire logic [PINS-1:0] sp_pin_oe_out
);
   logic live;
   logic sck_d;
   logic [PINS-1:0] own_lo;
   logic [PINS-1:0] own_in;
   logic [PINS-1:0] pin_d;
   always_ff @(posedge ref_clk_in) begin
      live <= nrst_in;
      sck_d <= sp_periph_data_in[5];
      own_lo <= fp_periph_en_in & fp_periph_dir_in & ~fp_periph_data_in;
      own_in <= fp_periph_en_in & ~fp_periph_dir_in;
      pin_d <= fp_pin_in;
   end
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!nrst_in);
   sequence s_sck_req;
      sp_periph_en_in[5] && sp_periph_dir_in[5];
   endsequence
   sequence s_sck_drive;
      sp_pin_oe_out[5] && (sp_pin_out[5] == sck_d);
   endsequence
   property p_ready; hreadyout_out; endproperty
   property p_okay; !hresp_out; endproperty
   property p_hi_zero; hrdata_out[31:8] == 24'h00_0000; endproperty
   property p_pull_excl; (fp_pull_up_out & fp_pull_dn_out) == '0; endproperty
   property p_pull_od; (fp_pin_oe_out & fp_pin_out & (fp_pull_up_out | fp_pull_dn_out)) == '0;
   endproperty
   property p_force_lo; live |-> ((fp_pin_oe_out & own_lo) == own_lo) && ((fp_pin_out & own_lo) == '0);
   endproperty
   property p_force_in; live |-> (fp_pin_oe_out & own_in) == '0; endproperty
   property p_sck; s_sck_req |=> s_sck_drive; endproperty
   property p_rx; live |-> fp_periph_rx_out == pin_d; endproperty
   a_ready: assert property (p_ready) else $error("hreadyout low");
   a_okay: assert property (p_okay) else $error("hresp not okay");
   a_hi_zero: assert property (p_hi_zero) else $error("hrdata upper bits set");
   a_pull_excl: assert property (p_pull_excl) else $error("pull up and down together");
   a_pull_od: assert property (p_pull_od) else $error("pull on push-pull high");
   a_force_lo: assert property (p_force_lo) else $error("owned low not driven");
   a_force_in: assert property (p_force_in) else $error("owned input driven");
   a_sck: assert property (p_sck) else $error("serial clock not routed");
   a_rx: assert property (p_rx) else $error("rx not one edge behind pin");
endmodule : pup_top_monitor
bind pup_top pup_top_monitor #(.PINS(PINS)) mon (.ref_clk_in, .nrst_in, .hrdata_out,
   .hreadyout_out, .hresp_out, .fp_pin_in, .fp_pin_out, .fp_pin_oe_out, .fp_pull_up_out,
   .fp_pull_dn_out, .fp_periph_en_in, .fp_periph_dir_in, .fp_periph_data_in,
   .fp_periph_rx_out, .sp_periph_en_in, .sp_periph_dir_in, .sp_periph_data_in, .sp_pin_out,
   .sp_pin_oe_out);
`default_nettype wire

/* File: pup_top_tb.sv */
// Purpose: register and pad checks of the port pad unit
// Assumes: zero wait slave, pads settle two edges after a write
// Notes: second port pins also driven from an outside source
`timescale 1ns/1ns
`default_nettype none
`include "pup_params.svh"
module pup_top_tb;
   import pup_pkg::*;
   logic ref_clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic hsel_in = 1'b0;
   logic hwrite_in = 1'b0;
   logic [1:0] htrans_in = 2'h0;
   logic [2:0] hsize_in = `PUP_HSIZE_WORD;
   logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, hrdata_out, rd;
   logic hreadyout_out, hresp_out;
   logic [7:0] fp_pin_in, fp_pin_out, fp_pin_oe_out, fp_pull_up_out, fp_pull_dn_out;
   logic [7:0] fp_periph_rx_out, sp_pin_in, sp_pin_out, sp_pin_oe_out, sp_periph_rx_out;
   logic [7:0] fp_periph_en_in = 8'h00, fp_periph_dir_in = 8'h00, fp_periph_data_in = 8'h00;
   logic [7:0] sp_periph_en_in = 8'h00, sp_periph_dir_in = 8'h00, sp_periph_data_in = 8'h00;
   // outside drive on the first port holds pins still until the reset reads are done
   logic [7:0] fp_ext_en = 8'hff, sp_ext_val = 8'h3c;
   logic [7:0] offs [4] = '{`PUP_OFF_PULL_EN, `PUP_OFF_PULL_POL, `PUP_OFF_OD_SEL, `PUP_OFF_RSVD};
   logic [7:0] wv [4] = '{8'ha5, 8'h0f, 8'h3c, 8'hff};
   logic [7:0] ev [4] = '{8'ha5, 8'h0f, 8'h3c, 8'h00};
   int err_total = 0, tests_run = 0, cycles = 0;
   pup_top #(.PINS(8)) uut (.ref_clk_in, .nrst_in, .hsel_in, .haddr_in, .htrans_in,
      .hwrite_in, .hsize_in, .hwdata_in, .hready_in(hreadyout_out), .hrdata_out,
      .hreadyout_out, .hresp_out, .fp_pin_in, .fp_pin_out, .fp_pin_oe_out, .fp_pull_up_out,
      .fp_pull_dn_out, .fp_periph_en_in, .fp_periph_dir_in, .fp_periph_data_in,
      .fp_periph_rx_out, .sp_pin_in, .sp_pin_out, .sp_pin_oe_out, .sp_periph_en_in,
      .sp_periph_dir_in, .sp_periph_data_in, .sp_periph_rx_out);
   pup_pin_model fp_pads (.ref_clk_in, .oe_in(fp_pin_oe_out), .out_in(fp_pin_out),
      .up_in(fp_pull_up_out), .dn_in(fp_pull_dn_out), .ext_en_in(fp_ext_en), .ext_val_in(8'h00),
      .pin_out(fp_pin_in));
   pup_pin_model sp_pads (.ref_clk_in, .oe_in(sp_pin_oe_out), .out_in(sp_pin_out),
      .up_in(8'h00), .dn_in(8'h00), .ext_en_in(8'hff), .ext_val_in(sp_ext_val),
      .pin_out(sp_pin_in));
   initial begin
      forever #5 ref_clk_in = ~ref_clk_in;
   end
   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : summarize
   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 5000) begin
         err_total++;
         summarize();
      end
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // waits on hready rather than assuming the zero wait answer
   task automatic bus(input logic wr, input logic [7:0] off, input logic [31:0] wd);
      @(posedge ref_clk_in);
      haddr_in <= {`PUP_PAD_ZERO, off};
      hwrite_in <= wr;
      hsel_in <= 1'b1;
      htrans_in <= 2'h2;
      @(posedge ref_clk_in);
      while (hreadyout_out !== 1'b1) @(posedge ref_clk_in);
      htrans_in <= 2'h0;
      hsel_in <= 1'b0;
      hwdata_in <= wd;
      @(posedge ref_clk_in);
      while (hreadyout_out !== 1'b1) @(posedge ref_clk_in);
      rd = hrdata_out;
   endtask : bus
   task automatic rchk(input string what, input logic [7:0] off, input logic [7:0] exp);
      bus(1'b0, off, 32'h0);
      chk(what, rd, {`PUP_PAD_ZERO, exp});
   endtask : rchk
   task automatic settle();
      repeat (2) @(posedge ref_clk_in);
      #1;
   endtask : settle
   initial begin
      repeat (5) @(posedge ref_clk_in);
      nrst_in <= 1'b1;
      // second port data reads pin state while every direction bit is zero
      for (int i = 0; i < 10; i++) rchk("reset value", 8'(4 * i), (i == 4) ? sp_ext_val : 8'h00);
      rchk("unmapped", 8'h40, 8'h00);
      $display("test reset done");
      fp_ext_en <= 8'h00;
      for (int i = 0; i < 4; i++) bus(1'b1, offs[i], {`PUP_PAD_ZERO, wv[i]});
      bus(1'b1, 8'h40, 32'h0000_00ff);
      for (int i = 0; i < 4; i++) rchk("readback", offs[i], ev[i]);
      $display("test registers done");
      settle();
      chk("in pull up", fp_pull_up_out, 8'ha0);
      chk("in pull dn", fp_pull_dn_out, 8'h05);
      chk("in oe", fp_pin_oe_out, 8'h00);
      // unpulled pins wander, so only pulled bits are compared
      bus(1'b0, `PUP_OFF_FP_PIN, 32'h0);
      chk("in pin pulls", rd & 32'h0000_00a5, 32'h0000_00a0);
      bus(1'b1, `PUP_OFF_FP_DIR, 32'h0000_00ff);
      bus(1'b1, `PUP_OFF_FP_DATA, 32'h0000_00f0);
      settle();
      chk("out pull up", fp_pull_up_out, 8'h20);
      chk("out pull dn", fp_pull_dn_out, 8'h04);
      chk("out oe", fp_pin_oe_out, 8'hcf);
      chk("out drive", fp_pin_out & fp_pin_oe_out, 8'hc0);
      // bit 4 is an undriven wired-or one with no pull, so it is masked
      bus(1'b0, `PUP_OFF_FP_PIN, 32'h0);
      chk("wired-or pins", rd & 32'h0000_00ef, 32'h0000_00e0);
      $display("test first port done");
      @(posedge ref_clk_in);
      fp_periph_en_in <= 8'h3f;
      fp_periph_dir_in <= 8'h0f;
      fp_periph_data_in <= 8'h05;
      settle();
      chk("owned oe", fp_pin_oe_out, 8'hcb);
      chk("owned drive", fp_pin_out & fp_pin_oe_out, 8'hc1);
      chk("owned pull up", fp_pull_up_out, 8'h20);
      rchk("dir kept", `PUP_OFF_FP_DIR, 8'hff);
      $display("test peripheral done");
      bus(1'b1, `PUP_OFF_SP_DIR, 32'h0000_000f);
      bus(1'b1, `PUP_OFF_SP_DATA, 32'h0000_00a5);
      settle();
      rchk("sp data mix", `PUP_OFF_SP_DATA, 8'h35);
      chk("sp oe", sp_pin_oe_out, 8'h0f);
      chk("sp drive", sp_pin_out & sp_pin_oe_out, 8'h05);
      sp_ext_val <= 8'hc3;
      settle();
      rchk("sp data pin", `PUP_OFF_SP_DATA, 8'hc5);
      @(posedge ref_clk_in);
      sp_periph_en_in <= 8'he0;
      sp_periph_dir_in <= 8'he0;
      sp_periph_data_in <= 8'h20;
      settle();
      chk("sck oe", sp_pin_oe_out, 8'h2f);
      chk("sck drive", sp_pin_out & sp_pin_oe_out, 8'h25);
      $display("test second port done");
      summarize();
   end
endmodule : pup_top_tb
`default_nettype wire
